// ===== inc/pwiu_cfg.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef PWIU_CFG_SVH
`define PWIU_CFG_SVH
`define PWIU_OFS_CTRL    6'h00
`define PWIU_OFS_PIN_EN  6'h04
`define PWIU_OFS_EDGE    6'h08
`define PWIU_OFS_PEND    6'h0C
`define PWIU_OFS_XOLD    6'h10
`define PWIU_OFS_RTCC    6'h14
`define PWIU_OFS_ISTAT   6'h18
`define PWIU_OFS_IMASK   6'h1C
`define PWIU_CTRL_RTCC_IE 0
`define PWIU_CTRL_TMR1_IE 1
`define PWIU_CTRL_TMR2_IE 2
`define PWIU_CTRL_SLEEP   3
`define PWIU_IS_RTCC 0
`define PWIU_IS_PIN  1
`define PWIU_IS_TMR1 2
`define PWIU_IS_TMR2 3
`define PWIU_IS_WAKE 4
`define PWIU_RST_BYTE 8'h00
`define PWIU_RTCC_MAX 8'hFF
`define PWIU_VECTOR   12'h000
`define PWIU_LAT_RTCC 3
`define PWIU_LAT_PIN  5
`endif

// ===== inc/pwiu_pin_if.sv
// Carrier between the core and its pin edge and pending unit.
`timescale 1ns/100ps
interface pwiu_pin_if #(parameter int NPINS = 8);
  logic [NPINS-1:0] pins;      // Raw pin levels, asynchronous.
  logic [NPINS-1:0] en;        // Per-pin wakeup/interrupt enable.
  logic [NPINS-1:0] edge_fall; // Per-pin polarity, one selects falling.
  logic             xchg_we;   // One-cycle exchange write strobe.
  logic [NPINS-1:0] xchg_data; // Value stored by the exchange.
  logic [NPINS-1:0] pend;      // Pending flags.
  logic [NPINS-1:0] evt;       // One-cycle pulse per newly caught edge.
  modport core (output pins, en, edge_fall, xchg_we, xchg_data,
                input pend, evt);
  modport unit (input pins, en, edge_fall, xchg_we, xchg_data,
                output pend, evt);
endinterface : pwiu_pin_if

// ===== inc/pwiu_pkg.sv
// Types shared by the wakeup and interrupt unit.
package pwiu_pkg;
  // Interrupt sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_WAIT    = 2'b01,
    ST_SERVICE = 2'b10,
    ST_RESTORE = 2'b11
  } pwiu_state_t;
endpackage : pwiu_pkg

// ===== src/pwiu_core.sv
// Port wakeup and interrupt unit with context shadow and return logic.
// Contract
// - Edge wakes and resets in power down
// - Eight pins, each with own enable
// - Per-pin rising or falling edge select
// - One pending flag per pin, set on edge
// - Extra timer interrupts with own enables
// - Two returns restore working, status, pointer, pc
// - Adding return adds working to counter first
// - Service routine starts at address zero
// - Pending access swaps flags with written value
// - Bit n of pending flags is pin n
// - No new entry until return
// - Flags keep capturing during service
// - Entry latency three counter, five pin
// - Counter rollover raises interrupt when enabled
`timescale 1ns/100ps
`include "pwiu_cfg.svh"
module pwiu_core #(
  parameter int NPINS = 8
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Avalon-MM slave.
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Port pins and event sources.
  input  wire logic [7:0]  port_pins,
  input  wire logic        rtcc_tick,
  input  wire logic        extra_timer_one,
  input  wire logic        extra_timer_two,
  // Processor context and return requests.
  input  wire logic [7:0]  cpu_w,
  input  wire logic [7:0]  cpu_status,
  input  wire logic [7:0]  cpu_fsr,
  input  wire logic [11:0] cpu_pc,
  input  wire logic        ret_plain,
  input  wire logic        return_from_irq_add_acc,
  // Sequencer, wakeup reset, counter and interrupt line outputs.
  output logic             vec_go,
  output logic [11:0]      vec_addr,
  output logic             ctx_restore,
  output logic [7:0]       rst_w,
  output logic [7:0]       rst_status,
  output logic [7:0]       rst_fsr,
  output logic [11:0]      rst_pc,
  output logic             wake_reset,
  output logic             in_service,
  output logic [7:0]       rtcc_value,
  output logic             irq
);
  if (NPINS != 8 || `PWIU_LAT_RTCC < 2 || `PWIU_LAT_PIN < 2)
  begin : g_chk
    $error("pwiu_core: eight pins and latencies of two or more only");
  end

  pwiu_pin_if #(.NPINS(NPINS)) pif ();

  pwiu_pin_unit #(.NPINS(NPINS)) u_pins (
    .clk   (clk),
    .rst_n (rst_n),
    .pif   (pif)
  );

  pwiu_pkg::pwiu_state_t st_r;        // Sequencer state.
  logic [3:0]            ctrl_r;      // Interrupt enables; bit 3 is always written zero.
  logic [7:0]            pin_en_r;    // Pin enables.
  logic [7:0]            edge_r;      // Pin polarity selects.
  logic [7:0]            xold_r;      // Flags read out by last exchange.
  logic [7:0]            rtcc_r;      // Real-time counter.
  logic [4:0]            istat_r;     // Sticky event bits.
  logic [4:0]            imask_r;     // Event mask.
  logic                  pd_r;        // Power down.
  logic [2:0]            cnt_r;       // Entry latency down-counter.
  logic [7:0]            sh_w_r;      // Shadow working register.
  logic [7:0]            sh_st_r;     // Shadow status.
  logic [7:0]            sh_fsr_r;    // Shadow file select pointer.
  logic [11:0]           sh_pc_r;     // Shadow program counter.
  logic [31:0]           rdata_r;
  logic                  wait_r;
  logic                  vec_r;
  logic                  rest_r;
  logic                  wake_r;
  logic                  irq_r;

  // Bus decode: one wait state, the request is taken when wait is low.
  wire       acc    = avs_read | avs_write;
  wire       wr_go  = avs_write & ~wait_r & avs_byteenable[0];
  wire [7:0] wb     = avs_writedata[7:0];
  wire       wr_ctl = wr_go && avs_address == `PWIU_OFS_CTRL;
  wire       wr_en  = wr_go && avs_address == `PWIU_OFS_PIN_EN;
  wire       wr_edg = wr_go && avs_address == `PWIU_OFS_EDGE;
  wire       wr_pnd = wr_go && avs_address == `PWIU_OFS_PEND;
  wire       wr_rtc = wr_go && avs_address == `PWIU_OFS_RTCC;
  wire       wr_ist = wr_go && avs_address == `PWIU_OFS_ISTAT;
  wire       wr_msk = wr_go && avs_address == `PWIU_OFS_IMASK;

  // Read mux; bit n of the flags is pin n, unmapped words read zero.
  wire [7:0] rd_byte =
    (avs_address == `PWIU_OFS_CTRL)   ? {4'h0, ctrl_r[3] ? 1'b1 : pd_r,
                                         ctrl_r[2:0]} :
    (avs_address == `PWIU_OFS_PIN_EN) ? pin_en_r :
    (avs_address == `PWIU_OFS_EDGE)   ? edge_r :
    (avs_address == `PWIU_OFS_PEND)   ? pif.pend :
    (avs_address == `PWIU_OFS_XOLD)   ? xold_r :
    (avs_address == `PWIU_OFS_RTCC)   ? rtcc_r :
    (avs_address == `PWIU_OFS_ISTAT)  ? {3'h0, istat_r} :
    (avs_address == `PWIU_OFS_IMASK)  ? {3'h0, imask_r} : 8'h00;

  // Exchange: the written value goes into the flags, old flags are kept.
  assign pif.pins      = port_pins;
  assign pif.en        = pin_en_r;
  assign pif.edge_fall = edge_r;
  assign pif.xchg_we   = wr_pnd;
  assign pif.xchg_data = wb;

  // Request sources.
  wire pin_evt_any = |pif.evt;
  wire pin_req     = (|(pif.pend & pin_en_r)) & ~pd_r;
  wire oth_req     = (istat_r[`PWIU_IS_RTCC] & ctrl_r[`PWIU_CTRL_RTCC_IE]) |
                     (istat_r[`PWIU_IS_TMR1] & ctrl_r[`PWIU_CTRL_TMR1_IE]) |
                     (istat_r[`PWIU_IS_TMR2] & ctrl_r[`PWIU_CTRL_TMR2_IE]);
  wire req         = pin_req | oth_req;
  wire ret_any     = ret_plain | return_from_irq_add_acc;
  wire add_now     = (st_r == pwiu_pkg::ST_SERVICE) & return_from_irq_add_acc;
  wire roll        = rtcc_tick & (rtcc_r == `PWIU_RTCC_MAX) &
                     ~add_now & ~wr_rtc;
  // Pin latency dominates when a pin is among the causes.
  wire [2:0] lat0  = pin_req ? 3'(`PWIU_LAT_PIN - 2) :
                               3'(`PWIU_LAT_RTCC - 2);

  // Event set wins over a one-to-clear in the same cycle.
  wire [4:0] ev_set = {pd_r & pin_evt_any, extra_timer_two,
                       extra_timer_one, ~pd_r & pin_evt_any, roll};
  wire [4:0] istat_nxt = (istat_r & ~(wr_ist ? wb[4:0] : 5'h00)) | ev_set;

  // Bus slave handshake and read data.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      wait_r  <= ~(acc & wait_r);
      rdata_r <= (avs_read & wait_r) ? {24'h00_0000, rd_byte} : rdata_r;
    end
  end

  // Software-written configuration.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r   <= 4'h0;
      pin_en_r <= `PWIU_RST_BYTE;
      edge_r   <= `PWIU_RST_BYTE;
      imask_r  <= 5'h00;
      xold_r   <= `PWIU_RST_BYTE;
    end
    else
    begin
      ctrl_r   <= wr_ctl ? {1'b0, wb[2:0]} : ctrl_r;
      pin_en_r <= wr_en ? wb : pin_en_r;
      edge_r   <= wr_edg ? wb : edge_r;
      imask_r  <= wr_msk ? wb[4:0] : imask_r;
      xold_r   <= wr_pnd ? pif.pend : xold_r;
    end
  end

  // Counter: the adding return beats a bus write, which beats a tick.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rtcc_r <= `PWIU_RST_BYTE;
    else if (add_now)
      rtcc_r <= rtcc_r + cpu_w;
    else if (wr_rtc)
      rtcc_r <= wb;
    else if (rtcc_tick)
      rtcc_r <= rtcc_r + 8'h01;
  end

  // Power down, wakeup reset, sticky events and interrupt line.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pd_r    <= 1'b0;
      wake_r  <= 1'b0;
      istat_r <= 5'h00;
      irq_r   <= 1'b0;
    end
    else
    begin
      // A pin edge while asleep resets the device instead of vectoring.
      pd_r    <= (pd_r & ~pin_evt_any) | (wr_ctl & wb[`PWIU_CTRL_SLEEP]);
      wake_r  <= pd_r & pin_evt_any;
      istat_r <= istat_nxt;
      irq_r   <= |(istat_nxt & imask_r);
    end
  end

  // Interrupt sequencer.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r   <= pwiu_pkg::ST_IDLE;
      cnt_r  <= 3'h0;
      vec_r  <= 1'b0;
      rest_r <= 1'b0;
    end
    else
    begin
      vec_r  <= 1'b0;
      rest_r <= 1'b0;
      unique case (st_r)
        pwiu_pkg::ST_IDLE:
        begin
          // Re-entry right after a restore when a cause is still pending.
          if (req)
          begin
            st_r  <= pwiu_pkg::ST_WAIT;
            cnt_r <= lat0;
          end
        end
        pwiu_pkg::ST_WAIT:
        begin
          if (cnt_r == 3'h0)
          begin
            vec_r <= 1'b1;
            st_r  <= pwiu_pkg::ST_SERVICE;
          end
          else
            cnt_r <= cnt_r - 3'h1;
        end
        pwiu_pkg::ST_SERVICE:
        begin
          // Further requests are held off until a return.
          if (ret_any)
            st_r <= pwiu_pkg::ST_RESTORE;
        end
        pwiu_pkg::ST_RESTORE:
        begin
          rest_r <= 1'b1;
          st_r   <= pwiu_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Shadow registers catch the context when an entry starts.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh_w_r   <= 8'h00;
      sh_st_r  <= 8'h00;
      sh_fsr_r <= 8'h00;
      sh_pc_r  <= 12'h000;
    end
    else if (st_r == pwiu_pkg::ST_IDLE && req)
    begin
      sh_w_r   <= cpu_w;
      sh_st_r  <= cpu_status;
      sh_fsr_r <= cpu_fsr;
      sh_pc_r  <= cpu_pc;
    end
  end

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign vec_go          = vec_r;
  assign vec_addr        = `PWIU_VECTOR;
  assign ctx_restore     = rest_r;
  assign rst_w           = sh_w_r;
  assign rst_status      = sh_st_r;
  assign rst_fsr         = sh_fsr_r;
  assign rst_pc          = sh_pc_r;
  assign wake_reset      = wake_r;
  assign in_service      = st_r != pwiu_pkg::ST_IDLE;
  assign rtcc_value      = rtcc_r;
  assign irq             = irq_r;

  sequence s_ret;
    st_r == pwiu_pkg::ST_SERVICE && ret_any;
  endsequence
  sequence s_restore;
    ##1 st_r == pwiu_pkg::ST_RESTORE ##1 rest_r;
  endsequence

  a_pin_latency: assert property (@(posedge clk) disable iff (!rst_n)
    st_r == pwiu_pkg::ST_IDLE && pin_req |-> !vec_r [*5] ##1 vec_r)
    else $error("pin entry latency wrong");
  a_rtcc_latency: assert property (@(posedge clk) disable iff (!rst_n)
    st_r == pwiu_pkg::ST_IDLE && !pin_req && oth_req |-> ##3 vec_r)
    else $error("counter entry latency wrong");
  a_hold_service: assert property (@(posedge clk) disable iff (!rst_n)
    st_r == pwiu_pkg::ST_SERVICE && !ret_any |=> !vec_r && in_service)
    else $error("entry during service");
  a_return_restore: assert property (@(posedge clk) disable iff (!rst_n)
    s_ret |-> s_restore)
    else $error("return did not restore");
  a_add_first: assert property (@(posedge clk) disable iff (!rst_n)
    s_ret and return_from_irq_add_acc |=>
      rtcc_r == 8'($past(rtcc_r) + $past(cpu_w)) && !rest_r ##1 rest_r)
    else $error("add not before restore");
  a_save_context: assert property (@(posedge clk) disable iff (!rst_n)
    st_r == pwiu_pkg::ST_IDLE && req |=> sh_pc_r == $past(cpu_pc)
      && sh_w_r == $past(cpu_w))
    else $error("context not saved");
  a_rollover_flag: assert property (@(posedge clk) disable iff (!rst_n)
    roll |=> istat_r[`PWIU_IS_RTCC] && rtcc_r == 8'h00)
    else $error("rollover not flagged");
  a_wake_reset: assert property (@(posedge clk) disable iff (!rst_n)
    pd_r && pin_evt_any |=> wake_r && !pd_r && !vec_r)
    else $error("wakeup reset missing");
  a_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    (pif.pend & pin_en_r) != 8'h00 && !wr_pnd && $stable(pin_en_r)
      |=> (pif.pend & $past(pif.pend)) == $past(pif.pend))
    else $error("pending flag lost");
  a_exchange_old: assert property (@(posedge clk) disable iff (!rst_n)
    wr_pnd |=> xold_r == $past(pif.pend))
    else $error("exchange readout wrong");
endmodule : pwiu_core

// ===== src/pwiu_pin_unit.sv
// Pin synchroniser, edge detector and pending flag register.
`timescale 1ns/100ps
module pwiu_pin_unit #(
  parameter int NPINS = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Link to the core.
  pwiu_pin_if.unit pif
);
  logic [NPINS-1:0] sync1_r;   // First synchroniser stage.
  logic [NPINS-1:0] sync2_r;   // Second synchroniser stage.
  logic [NPINS-1:0] prev_r;    // Level one cycle earlier.
  logic [NPINS-1:0] pend_r;    // Pending flags.
  logic [NPINS-1:0] evt_r;     // Caught-edge pulses.
  wire  [NPINS-1:0] rise = sync2_r & ~prev_r;
  wire  [NPINS-1:0] fall = ~sync2_r & prev_r;
  // Only enabled pins catch an edge of their chosen polarity.
  wire  [NPINS-1:0] hit  = pif.en & ((pif.edge_fall & fall) |
                                     (~pif.edge_fall & rise));
  // A caught edge wins over a clear landing in the same cycle.
  wire  [NPINS-1:0] base = pif.xchg_we ? pif.xchg_data : pend_r;
  wire  [NPINS-1:0] pend_nxt = base | hit;

  // Synchronise the pins; nothing but sync2_r reads sync1_r.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r  <= '0;
    end
    else
    begin
      sync1_r <= pif.pins;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // Flags keep capturing even while a routine is in service.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_r <= '0;
      evt_r  <= '0;
    end
    else
    begin
      pend_r <= pend_nxt;
      evt_r  <= hit;
    end
  end

  assign pif.pend = pend_r;
  assign pif.evt  = evt_r;
endmodule : pwiu_pin_unit

// ===== tb/pwiu_pin_src.sv
// Model of the external sources that drive the eight port pins.
`timescale 1ns/100ps
module pwiu_pin_src (
  // Clock.
  input  wire logic       clk,
  // One-cycle request to flip the chosen pins.
  input  wire logic [7:0] flip,
  // Pin levels seen by the device.
  output logic      [7:0] pins
);
  // Sources hold a steady level, so an edge comes only on request.
  initial pins = 8'h00;
  // Each flip makes one edge; its direction follows the last level.
  always @(posedge clk) pins <= pins ^ flip;
endmodule : pwiu_pin_src

// ===== tb/testbench.sv
// Self-checking bench for the wakeup and interrupt unit.
`timescale 1ns/100ps
`include "pwiu_cfg.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
module testbench;
  // Bench clock, reset and bus signals.
  logic        clk = 1'b0, rst_n = 1'b0;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000, avs_readdata;
  logic        avs_waitrequest;
  // Pin flips, event pulses, live context and returns.
  logic [7:0]  flip = 8'h00, pins;
  logic        rtcc_tick = 1'b0, tmr1 = 1'b0, tmr2 = 1'b0;
  logic [7:0]  cpu_w = 8'h5A, cpu_status = 8'hC3, cpu_fsr = 8'h3C;
  logic [11:0] cpu_pc = 12'h9A5;
  logic        ret_plain = 1'b0, ret_add = 1'b0;
  // Observed outputs.
  logic        vec_go, ctx_restore, wake_reset, in_service, irq;
  logic [11:0] vec_addr, rst_pc;
  logic [7:0]  rst_w, rst_status, rst_fsr, rtcc_value;
  // Counters of results and of observed pulses.
  int          fails = 0, check_count = 0, cyc = 0, n_vec = 0, n_wake = 0;
  int          n;

  always #4 clk = ~clk;

  pwiu_pin_src i_pwiu_pin_src (.clk(clk), .flip(flip), .pins(pins));

  pwiu_core #(.NPINS(8)) i_pwiu_core (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .port_pins(pins), .rtcc_tick(rtcc_tick), .extra_timer_one(tmr1),
    .extra_timer_two(tmr2), .cpu_w(cpu_w), .cpu_status(cpu_status),
    .cpu_fsr(cpu_fsr), .cpu_pc(cpu_pc), .ret_plain(ret_plain),
    .return_from_irq_add_acc(ret_add), .vec_go(vec_go),
    .vec_addr(vec_addr), .ctx_restore(ctx_restore), .rst_w(rst_w),
    .rst_status(rst_status), .rst_fsr(rst_fsr), .rst_pc(rst_pc),
    .wake_reset(wake_reset), .in_service(in_service),
    .rtcc_value(rtcc_value), .irq(irq));

  // Counts pulses so that a missing or extra entry shows later on.
  // It runs on the falling edge, so a pulse seen at a rising edge has
  // already been counted when a task compares the count there.
  always @(negedge clk)
  begin
    cyc++;
    n_vec  += (vec_go === 1'b1);
    n_wake += (wake_reset === 1'b1);
    if (cyc == 6000)
    begin
      fails++;
      tally_and_finish();
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // Writes one register; the request stands until waitrequest drops.
  task automatic bus_wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= {24'h000000, d};
    avs_write     <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : bus_wr

  // Reads one register and compares all 32 bits at the answer edge.
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    @(posedge clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    `CHK(avs_readdata, {24'h000000, e})
    avs_read <= 1'b0;
  endtask : rd_chk

  // Flips pins for one cycle; ends at the edge where the pins move.
  task automatic fire(input logic [7:0] m);
    @(posedge clk);
    flip <= m;
    @(posedge clk);
    flip <= 8'h00;
  endtask : fire

  // Waits, bounded, for vec_go (0), ctx_restore (1) or wake_reset (2).
  task automatic wait_hi(input int sel, output int k);
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while ((sel == 2 ? wake_reset : sel == 1 ? ctx_restore : vec_go)
           !== 1'b1 && k < 40);
  endtask : wait_hi

  // Issues a return pulse and times the restore that follows it.
  task automatic ret(input logic add, output int k);
    @(posedge clk);
    ret_plain <= ~add;
    ret_add   <= add;
    @(posedge clk);
    ret_plain <= 1'b0;
    ret_add   <= 1'b0;
    wait_hi(1, k);
  endtask : ret

  // Main sequence; the pins are enabled before any edge is made.
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(`PWIU_OFS_CTRL, 8'h00);
    rd_chk(`PWIU_OFS_ISTAT, 8'h00);
    rd_chk(6'h20, 8'h00);
    bus_wr(`PWIU_OFS_EDGE, 8'h02);
    bus_wr(`PWIU_OFS_PIN_EN, 8'h03);
    bus_wr(`PWIU_OFS_IMASK, 8'h02);
    fire(8'h01);
    wait_hi(0, n);
    // Pins move at the edge where fire returns; flag is 3 edges on.
    `CHK(n, `PWIU_LAT_PIN + 4)
    `CHK(vec_addr, `PWIU_VECTOR)
    `CHK(in_service, 1'b1)
    `CHK(irq, 1'b1)
    bus_wr(`PWIU_OFS_IMASK, 8'h00);
    rd_chk(`PWIU_OFS_ISTAT, 8'h02);
    `CHK(irq, 1'b0)
    bus_wr(`PWIU_OFS_IMASK, 8'h02);
    // Pin one rises first, which its falling polarity must ignore.
    fire(8'h02);
    fire(8'h02);
    fire(8'h04);
    cpu_w <= 8'h11;
    rd_chk(`PWIU_OFS_PEND, 8'h03);
    `CHK(n_vec, 1)
    `CHK(irq, 1'b1)
    // The exchange keeps pin one and clears pin zero.
    bus_wr(`PWIU_OFS_PEND, 8'h02);
    rd_chk(`PWIU_OFS_XOLD, 8'h03);
    rd_chk(`PWIU_OFS_PEND, 8'h02);
    ret(1'b0, n);
    `CHK(n, 2)
    `CHK({rst_w, rst_status, rst_fsr}, 24'h5AC33C)
    `CHK(rst_pc, 12'h9A5)
    wait_hi(0, n);
    `CHK(n_vec, 2)
    bus_wr(`PWIU_OFS_PEND, 8'h00);
    bus_wr(`PWIU_OFS_ISTAT, 8'h1F);
    rd_chk(`PWIU_OFS_PEND, 8'h00);
    `CHK(irq, 1'b0)
    ret(1'b0, n);
    // Counter rollover, then the adding return.
    bus_wr(`PWIU_OFS_CTRL, 8'h01);
    bus_wr(`PWIU_OFS_RTCC, 8'hFF);
    @(posedge clk);
    rtcc_tick <= 1'b1;
    @(posedge clk);
    rtcc_tick <= 1'b0;
    wait_hi(0, n);
    `CHK(n, `PWIU_LAT_RTCC + 1)
    `CHK(rtcc_value, 8'h00)
    bus_wr(`PWIU_OFS_ISTAT, 8'h01);
    ret(1'b1, n);
    `CHK(rtcc_value, 8'h11)
    `CHK(rst_w, 8'h11)
    // Both extra timers, each with its own enable and mask bit.
    for (int i = 0; i < 2; i++)
    begin
      bus_wr(`PWIU_OFS_CTRL, 8'h02 << i);
      bus_wr(`PWIU_OFS_IMASK, 8'h04 << i);
      @(posedge clk);
      tmr1 <= (i == 0);
      tmr2 <= (i == 1);
      @(posedge clk);
      tmr1 <= 1'b0;
      tmr2 <= 1'b0;
      wait_hi(0, n);
      `CHK(n, `PWIU_LAT_RTCC + 1)
      `CHK(irq, 1'b1)
      rd_chk(`PWIU_OFS_ISTAT, 8'h04 << i);
      bus_wr(`PWIU_OFS_ISTAT, 8'h04 << i);
      ret(1'b0, n);
    end
    // Power down: a falling edge on pin zero is ignored, a rise wakes.
    bus_wr(`PWIU_OFS_CTRL, 8'h08);
    fire(8'h01);
    fire(8'h01);
    wait_hi(2, n);
    `CHK(n_wake, 1)
    `CHK(n_vec, 5)
    rd_chk(`PWIU_OFS_PEND, 8'h01);
    tally_and_finish();
  end
endmodule : testbench
